// *** modulo_position_defs.svh ***
// Offsets, field limits and reset values of the modulo position mapper
// Operation
// - Modulo mapping is off while the range enable setting is 0 and on while it is 1, and it resets to 0.
// - The range enable setting changes only while the power stage is disabled, and an accepted change acts at once.
// - The lower and upper range bounds are written only while the power stage is disabled and act at once.
// - After reset the lower range bound is 0 and the upper range bound is 3600 position units.
// - The absolute direction policy is 0 for shortest path, 1 for positive only, 2 for negative only, 0 after reset.
// - Under the shortest path policy the move takes the shorter way to the absolute target within the range.
// - Under the shortest path policy a tie between both directions moves in the positive direction.
// - A change of the direction policy acts at once, whether the power stage is enabled or not.
// - The multiple range option is 0 for one range and 1 for several ranges, 0 after reset, and acts at once.
// - With multiple ranges on, an absolute target beyond the range moves as if copies of the range were chained.
// - With modulo mapping on and the upper bound above the lower bound, every commanded target is mapped into the bounded repeating range before motion.
// - The direction policy and the multiple range option affect absolute targets only, never relative ones.
`ifndef MODULO_POSITION_DEFS_SVH
`define MODULO_POSITION_DEFS_SVH

// ----------------------------------------------------------------
// Parameter addresses
// ----------------------------------------------------------------
`define MPM_OFS_ENABLE    16'h0670
`define MPM_OFS_LOWER     16'h0672
`define MPM_OFS_UPPER     16'h0674
`define MPM_OFS_DIRECTION 16'h0676
`define MPM_OFS_MULTI     16'h0678

// ----------------------------------------------------------------
// Reset values and largest legal codes
// ----------------------------------------------------------------
`define MPM_RST_ENABLE    1'b0
`define MPM_RST_LOWER     32'h00000000
`define MPM_RST_UPPER     32'h00000e10
`define MPM_RST_DIRECTION 2'h0
`define MPM_RST_MULTI     1'b0
`define MPM_MAX_ENABLE    16'h0001
`define MPM_MAX_DIRECTION 16'h0002
`define MPM_MAX_MULTI     16'h0001

// ----------------------------------------------------------------
// Serial remainder unit
// ----------------------------------------------------------------
`define MPM_DIV_STEPS     6'h22

`endif

// *** modulo_position_mapper.sv ***
// Modulo position mapper: parameter registers and target mapping
`timescale 1ns/100ps
`default_nettype none
`include "modulo_position_defs.svh"

module modulo_position_mapper
  import modulo_position_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Parameter access
  input  wire logic        PAR_WR,
  input  wire logic        PAR_RD,
  input  wire logic [15:0] PAR_ADDR,
  input  wire logic [31:0] PAR_WDATA,
  output logic      [31:0] PAR_RDATA,
  output logic             PAR_RVALID,
  output logic             PAR_REJECT,
  // Drive state
  input  wire logic        POWER_STAGE_EN,
  // Target command
  input  wire logic        TGT_VALID,
  input  wire logic        TGT_ABS,
  input  wire logic [31:0] TGT_POS,
  input  wire logic [31:0] ACT_POS,
  output logic             TGT_BUSY,
  output logic             MAP_VALID,
  output logic      [31:0] MAP_TARGET,
  output logic      [33:0] MAP_DIST
);

  mapper_s     s_q;
  mapper_s     s_d;
  logic        wrap_done;
  logic [33:0] wrap_rem;
  logic [33:0] width;
  logic [33:0] lower_x;

  // Sign-extend a 32-bit position to the internal 34-bit width
  function automatic logic [33:0] sx(input logic [31:0] v);
    return {{2{v[31]}}, v};
  endfunction

  // Signed less-than on 34-bit internal values
  function automatic logic slt(input logic [33:0] a, input logic [33:0] b);
    return $signed(a) < $signed(b);
  endfunction

  // A 16-bit code is legal with a clear upper half and no value above the top code
  function automatic logic code_ok(input logic [31:0] v, input logic [15:0] top);
    return v[31:16] == 16'h0 && v[15:0] <= top;
  endfunction

  assign lower_x = sx(s_q.lower);
  assign width   = 34'(sx(s_q.upper) - lower_x);

  // ----------------------------------------------------------------
  // Remainder unit folds (position - lower) into 0 .. width-1
  // ----------------------------------------------------------------
  range_remainder u_rem (
    .clk     (CLOCK),
    .rst     (RST),
    .start   (s_q.start),
    .offset  (34'(s_q.cmd - lower_x)),
    .divisor (width),
    .done    (wrap_done),
    .result  (wrap_rem)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic        locked;
    logic        legal;
    logic [33:0] act_ofs;
    logic [33:0] diff;
    logic [33:0] fwd;
    logic        outside;
    locked  = 1'b0;
    legal   = 1'b0;
    act_ofs = 34'h0;
    diff    = 34'h0;
    fwd     = 34'h0;
    outside = 1'b0;
    s_d = s_q;
    s_d.rvalid    = 1'b0;
    s_d.reject    = 1'b0;
    s_d.start     = 1'b0;
    s_d.out_valid = 1'b0;

    // Parameter reads answer one cycle later; unknown addresses read 0
    if (PAR_RD) begin
      s_d.rvalid = 1'b1;
      unique case (PAR_ADDR)
        `MPM_OFS_ENABLE:    s_d.rdata = {31'h0, s_q.wrap_en};
        `MPM_OFS_LOWER:     s_d.rdata = s_q.lower;
        `MPM_OFS_UPPER:     s_d.rdata = s_q.upper;
        `MPM_OFS_DIRECTION: s_d.rdata = {30'h0, s_q.dir};
        `MPM_OFS_MULTI:     s_d.rdata = {31'h0, s_q.multi};
        default:            s_d.rdata = 32'h0;
      endcase
    end

    // Parameter writes; refused ones leave the value and pulse reject
    if (PAR_WR) begin
      unique case (PAR_ADDR)
        `MPM_OFS_ENABLE: begin
          locked = POWER_STAGE_EN;
          legal  = code_ok(PAR_WDATA, `MPM_MAX_ENABLE);
          if (!locked && legal) begin
            s_d.wrap_en = PAR_WDATA[0];
          end
        end
        `MPM_OFS_LOWER: begin
          locked = POWER_STAGE_EN;
          legal  = 1'b1;
          if (!locked) begin
            s_d.lower = PAR_WDATA;
          end
        end
        `MPM_OFS_UPPER: begin
          locked = POWER_STAGE_EN;
          legal  = 1'b1;
          if (!locked) begin
            s_d.upper = PAR_WDATA;
          end
        end
        `MPM_OFS_DIRECTION: begin
          legal = code_ok(PAR_WDATA, `MPM_MAX_DIRECTION);
          if (legal) begin
            s_d.dir = dir_policy_e'(PAR_WDATA[1:0]);
          end
        end
        `MPM_OFS_MULTI: begin
          legal = code_ok(PAR_WDATA, `MPM_MAX_MULTI);
          if (legal) begin
            s_d.multi = PAR_WDATA[0];
          end
        end
        default: legal = 1'b0;
      endcase
      s_d.reject = locked || !legal;
    end

    // Target mapping sequence
    unique case (s_q.st)
      ST_IDLE: begin
        if (TGT_VALID) begin
          s_d.is_abs = TGT_ABS;
          s_d.act    = sx(ACT_POS);
          // Relative targets are taken from the actual position
          s_d.cmd    = TGT_ABS ? sx(TGT_POS) : 34'(sx(ACT_POS) + sx(TGT_POS));
          // A range with no width cannot wrap, so it passes like mapping off
          if (s_q.wrap_en && !width[33] && width != 34'h0) begin
            s_d.start = 1'b1;
            s_d.st    = ST_WRAP;
          end else begin
            s_d.out_valid  = 1'b1;
            s_d.out_target = TGT_ABS ? TGT_POS : 32'(sx(ACT_POS) + sx(TGT_POS));
            s_d.out_dist   = TGT_ABS ? 34'(sx(TGT_POS) - sx(ACT_POS)) : sx(TGT_POS);
          end
        end
      end
      ST_WRAP: begin
        if (wrap_done) begin
          s_d.st         = ST_DONE;
          s_d.out_valid  = 1'b1;
          s_d.out_target = 32'(lower_x + wrap_rem);
          act_ofs = 34'(s_q.act - lower_x);
          diff    = 34'(wrap_rem - act_ofs);
          fwd     = diff[33] ? 34'(diff + width) : diff;
          outside = slt(s_q.cmd, lower_x) || !slt(s_q.cmd, sx(s_q.upper));
          if (!s_q.is_abs) begin
            s_d.out_dist = 34'(s_q.cmd - s_q.act);
          end else if (s_q.multi && outside) begin
            s_d.out_dist = 34'(s_q.cmd - s_q.act);
          end else begin
            unique case (s_q.dir)
              DIR_POSITIVE: s_d.out_dist = fwd;
              DIR_NEGATIVE: s_d.out_dist = (fwd == 34'h0) ? 34'h0 : 34'(fwd - width);
              // Tie goes forward: the equality sits on the positive side
              default:      s_d.out_dist = ({fwd[32:0], 1'b0} <= width) ? fwd : 34'(fwd - width);
            endcase
          end
        end
      end
      ST_DONE: s_d.st = ST_IDLE;
      default: s_d.st = ST_IDLE;
    endcase

    // Busy rides in its own flop so the output pin needs no state decode
    s_d.busy = s_d.st != ST_IDLE;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s_q         <= '0;
      s_q.wrap_en <= `MPM_RST_ENABLE;
      s_q.lower   <= `MPM_RST_LOWER;
      s_q.upper   <= `MPM_RST_UPPER;
      s_q.dir     <= dir_policy_e'(`MPM_RST_DIRECTION);
      s_q.multi   <= `MPM_RST_MULTI;
      s_q.st      <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs come straight from the state register
  // ----------------------------------------------------------------
  assign PAR_RDATA  = s_q.rdata;
  assign PAR_RVALID = s_q.rvalid;
  assign PAR_REJECT = s_q.reject;
  assign TGT_BUSY   = s_q.busy;
  assign MAP_VALID  = s_q.out_valid;
  assign MAP_TARGET = s_q.out_target;
  assign MAP_DIST   = s_q.out_dist;

endmodule
`default_nettype wire

// *** modulo_position_mapper_props.sv ***
// Port checker for the modulo position mapper
`timescale 1ns/100ps
`default_nettype none

module mapper_props (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        PAR_WR,
  input wire logic        PAR_RD,
  input wire logic [15:0] PAR_ADDR,
  input wire logic [31:0] PAR_WDATA,
  input wire logic        PAR_RVALID,
  input wire logic        PAR_REJECT,
  input wire logic        POWER_STAGE_EN,
  input wire logic        TGT_BUSY,
  input wire logic        MAP_VALID
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // One domain, so clock and reset are given once for all properties
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  property p_rd; PAR_RD |=> PAR_RVALID; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_en_lock; PAR_WR && POWER_STAGE_EN && PAR_ADDR == 16'h0670 |=> PAR_REJECT; endproperty
  a_en_lock: assert property (p_en_lock) else $error("enable write not refused");
  property p_bnd_lock; PAR_WR && POWER_STAGE_EN && PAR_ADDR inside {16'h0672, 16'h0674} |=> PAR_REJECT; endproperty
  a_bnd_lock: assert property (p_bnd_lock) else $error("bound write not refused");
  property p_dir_ok; PAR_WR && PAR_ADDR == 16'h0676 && PAR_WDATA <= 32'h2 |=> !PAR_REJECT; endproperty
  a_dir_ok: assert property (p_dir_ok) else $error("direction write refused");
  property p_dir_bad; PAR_WR && PAR_ADDR == 16'h0676 && PAR_WDATA > 32'h2 |=> PAR_REJECT; endproperty
  a_dir_bad: assert property (p_dir_bad) else $error("bad direction taken");
  property p_multi; PAR_WR && PAR_ADDR == 16'h0678 && PAR_WDATA > 32'h1 |=> PAR_REJECT; endproperty
  a_multi: assert property (p_multi) else $error("bad range option taken");
  // Mapping has a fixed latency, so the result slot is exact
  property p_lat; $rose(TGT_BUSY) |-> !MAP_VALID [*8] ##29 MAP_VALID; endproperty
  a_lat: assert property (p_lat) else $error("mapping latency wrong");
  property p_end; $fell(TGT_BUSY) |-> $past(MAP_VALID); endproperty
  a_end: assert property (p_end) else $error("busy fell without result");
endmodule

bind modulo_position_mapper mapper_props u_mapper_props (.CLOCK(CLOCK), .RST(RST), .PAR_WR(PAR_WR),
  .PAR_RD(PAR_RD), .PAR_ADDR(PAR_ADDR), .PAR_WDATA(PAR_WDATA), .PAR_RVALID(PAR_RVALID),
  .PAR_REJECT(PAR_REJECT), .POWER_STAGE_EN(POWER_STAGE_EN), .TGT_BUSY(TGT_BUSY), .MAP_VALID(MAP_VALID));
`default_nettype wire

// *** modulo_position_mapper_tb.sv ***
// Self-checking testbench for the modulo position mapper
`timescale 1ns/100ps
`default_nettype none

module modulo_position_mapper_tb;
  // ----------------------------------------------------------------
  // Stimulus and checking
  // ----------------------------------------------------------------
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        pse = 1'b0;
  logic        tgt_valid = 1'b0;
  logic        tgt_abs = 1'b0;
  logic [31:0] tgt_pos = 32'h0;
  logic [31:0] act_pos = 32'h0;
  logic [31:0] par_rdata, map_target;
  logic [15:0] par_addr;
  logic [31:0] par_wdata;
  logic [33:0] map_dist;
  logic        par_wr, par_rd, par_rvalid, par_reject, tgt_busy, map_valid;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #2 clock = ~clock;
  param_master u_param_master (.clock(clock), .par_wr(par_wr), .par_rd(par_rd), .par_addr(par_addr),
    .par_wdata(par_wdata), .par_rdata(par_rdata), .par_rvalid(par_rvalid), .par_reject(par_reject));
  modulo_position_mapper u_modulo_position_mapper (.CLOCK(clock), .RST(rst), .PAR_WR(par_wr),
    .PAR_RD(par_rd), .PAR_ADDR(par_addr), .PAR_WDATA(par_wdata), .PAR_RDATA(par_rdata),
    .PAR_RVALID(par_rvalid), .PAR_REJECT(par_reject), .POWER_STAGE_EN(pse), .TGT_VALID(tgt_valid),
    .TGT_ABS(tgt_abs), .TGT_POS(tgt_pos), .ACT_POS(act_pos), .TGT_BUSY(tgt_busy),
    .MAP_VALID(map_valid), .MAP_TARGET(map_target), .MAP_DIST(map_dist));
  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic rej);
    logic [31:0] q;
    logic        rv;
    logic        rj;
    u_param_master.access(1'b1, a, d, q, rv, rj);
    chk("reject", {33'h0, rj}, {33'h0, rej});
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic        rv;
    logic        rj;
    u_param_master.access(1'b0, a, 32'h0, q, rv, rj);
    chk("rvalid", {33'h0, rv}, 34'h1);
    chk("rdata", {2'b0, q}, {2'b0, e});
  endtask
  // Busy is low again by the time the next command is raised
  task automatic cmd(input logic ab, input logic [31:0] pos, input logic [31:0] act,
                     input logic [31:0] et, input logic [33:0] ed);
    @(posedge clock);
    tgt_valid <= 1'b1;
    tgt_abs <= ab;
    tgt_pos <= pos;
    act_pos <= act;
    @(posedge clock);
    tgt_valid <= 1'b0;
    tgt_pos <= ~pos;
    repeat (60) begin
      @(posedge clock);
      if (map_valid === 1'b1) break;
    end
    chk("map_valid", {33'h0, map_valid}, 34'h1);
    chk("target", {2'b0, map_target}, {2'b0, et});
    chk("dist", map_dist, ed);
    @(posedge clock);
    chk("busy", {33'h0, tgt_busy}, 34'h0);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic t_reset();
    rd(16'h0670, 32'h0);
    rd(16'h0672, 32'h0);
    rd(16'h0674, 32'he10);
    rd(16'h0676, 32'h0);
    rd(16'h0678, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_lock();
    @(posedge clock);
    pse <= 1'b1;
    wr(16'h0670, 32'h1, 1'b1);
    wr(16'h0672, 32'h5, 1'b1);
    wr(16'h0674, 32'h5, 1'b1);
    rd(16'h0672, 32'h0);
    wr(16'h0676, 32'h1, 1'b0);
    rd(16'h0676, 32'h1);
    wr(16'h0676, 32'h3, 1'b1);
    wr(16'h0678, 32'h2, 1'b1);
    wr(16'h0678, 32'h1, 1'b0);
    wr(16'h0678, 32'h0, 1'b0);
    wr(16'h0676, 32'h0, 1'b0);
    wr(16'h067a, 32'h0, 1'b1);
    @(posedge clock);
    pse <= 1'b0;
    $display("lock test done");
  endtask
  task automatic t_off();
    cmd(1'b1, 5000, 700, 5000, 4300);
    cmd(1'b0, 300, 700, 1000, 300);
    $display("pass-through test done");
  endtask
  task automatic t_on();
    wr(16'h0670, 32'h1, 1'b0);
    rd(16'h0670, 32'h1);
    cmd(1'b1, 5000, 700, 1400, 700);
    cmd(1'b1, 2500, 700, 2500, 1800);
    wr(16'h0676, 32'h1, 1'b0);
    cmd(1'b1, 500, 700, 500, 3400);
    wr(16'h0676, 32'h2, 1'b0);
    cmd(1'b1, 1500, 700, 1500, -2800);
    cmd(1'b0, -500, 700, 200, -500);
    cmd(1'b0, 3300, 700, 400, 3300);
    wr(16'h0676, 32'h0, 1'b0);
    wr(16'h0678, 32'h1, 1'b0);
    cmd(1'b1, 5000, 700, 1400, 4300);
    wr(16'h0678, 32'h0, 1'b0);
    wr(16'h0674, 200, 1'b0);
    wr(16'h0672, 100, 1'b0);
    cmd(1'b1, 470, 150, 170, 20);
    $display("mapping test done");
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_lock();
    t_off();
    t_on();
    wrap_up();
  end
endmodule
`default_nettype wire

// *** modulo_position_pkg.sv ***
// Types shared by the modulo position mapper and its remainder unit
package modulo_position_pkg;

  // ----------------------------------------------------------------
  // Direction policy for absolute moves
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DIR_SHORTEST = 2'b00,
    DIR_POSITIVE = 2'b01,
    DIR_NEGATIVE = 2'b10
  } dir_policy_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRAP = 2'b01,
    ST_DONE = 2'b10
  } mapper_state_e;

  // ----------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [33:0] rem;
    logic [33:0] dvd;
    logic [5:0]  cnt;
    logic        busy;
    logic        neg;
    logic        done;
    logic [33:0] result;
  } divider_s;

  typedef struct packed {
    logic          wrap_en;
    logic [31:0]   lower;
    logic [31:0]   upper;
    dir_policy_e   dir;
    logic          multi;
    logic [31:0]   rdata;
    logic          rvalid;
    logic          reject;
    mapper_state_e st;
    logic          is_abs;
    logic [33:0]   cmd;
    logic [33:0]   act;
    logic          start;
    logic          busy;
    logic          out_valid;
    logic [31:0]   out_target;
    logic [33:0]   out_dist;
  } mapper_s;

endpackage

// *** param_master.sv ***
// Parameter bus master model standing in for the commissioning tool
`timescale 1ns/100ps
`default_nettype none

module param_master (
  input  wire logic        clock,
  output logic             par_wr,
  output logic             par_rd,
  output logic      [15:0] par_addr,
  output logic      [31:0] par_wdata,
  input  wire logic [31:0] par_rdata,
  input  wire logic        par_rvalid,
  input  wire logic        par_reject
);
  // ----------------------------------------------------------------
  // Accesses
  // ----------------------------------------------------------------
  // Idle bus at time zero
  initial begin
    par_wr = 1'b0;
    par_rd = 1'b0;
    par_addr = 16'h0000;
    par_wdata = 32'h00000000;
  end
  // One-cycle strobe; the answer is sampled one edge after it is taken
  task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic rv, output logic rj);
    @(posedge clock);
    par_wr <= wr;
    par_rd <= ~wr;
    par_addr <= a;
    par_wdata <= d;
    @(posedge clock);
    par_wr <= 1'b0;
    par_rd <= 1'b0;
    par_wdata <= ~d; // Released data must not look still valid
    @(posedge clock);
    q = par_rdata;
    rv = par_rvalid;
    rj = par_reject;
  endtask
endmodule
`default_nettype wire

// *** range_remainder.sv ***
// Serial unit that folds a signed offset into the range 0 .. divisor-1
`timescale 1ns/100ps
`default_nettype none
`include "modulo_position_defs.svh"

module range_remainder
  import modulo_position_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [33:0] offset,
  input  wire logic [33:0] divisor,
  output logic             done,
  output logic [33:0]      result
);

  divider_s s_q;
  divider_s s_d;
  logic [33:0] shifted;

  // ----------------------------------------------------------------
  // Shift-subtract, one bit per cycle; slow but small, a move is rare
  // ----------------------------------------------------------------
  always_comb begin
    s_d     = s_q;
    shifted = {s_q.rem[32:0], s_q.dvd[33]};
    s_d.done = 1'b0;
    if (start && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.neg  = offset[33];
      s_d.dvd  = offset[33] ? 34'(-offset) : offset;
      s_d.rem  = 34'h0;
      s_d.cnt  = `MPM_DIV_STEPS;
    end else if (s_q.busy) begin
      s_d.rem = (shifted >= divisor) ? 34'(shifted - divisor) : shifted;
      s_d.dvd = {s_q.dvd[32:0], 1'b0};
      s_d.cnt = 6'(s_q.cnt - 6'h01);
      if (s_q.cnt == 6'h01) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        // Negative offsets fold back from the top of the range
        s_d.result = (s_q.neg && s_d.rem != 34'h0) ? 34'(divisor - s_d.rem) : s_d.rem;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done   = s_q.done;
  assign result = s_q.result;

endmodule
`default_nettype wire
